// [xcau_pkg.sv]
package xcau_pkg;

   localparam int ACC_W = 32;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 4;
   localparam int OP_W = 4;
   localparam int CNT_W = 6;
   localparam int FIELD_MAX = 32;
   localparam int DISC_BITS = 1024;
   localparam int DISC_IDX_W = 10;
   localparam int STACK_DEPTH = 8;

   // Register offsets on the plain register port.
   localparam logic [ADDR_W-1:0] REG_ACC = 4'h0;
   localparam logic [ADDR_W-1:0] REG_OPER_LO = 4'h1;
   localparam logic [ADDR_W-1:0] REG_OPER_HI = 4'h2;
   localparam logic [ADDR_W-1:0] REG_FIELD = 4'h3;
   localparam logic [ADDR_W-1:0] REG_CMD = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
   localparam logic [ADDR_W-1:0] REG_STACK = 4'h6;
   localparam logic [ADDR_W-1:0] REG_DEPTH = 4'h7;

   // Field layout of the bit-field register.
   localparam int FIELD_START_LSB = 0;
   localparam int FIELD_COUNT_LSB = 16;

   // Bit positions in the status register.
   localparam int ST_ZERO = 0;
   localparam int ST_NEG = 1;
   localparam int ST_LESS = 2;
   localparam int ST_EQUAL = 3;
   localparam int ST_GREATER = 4;
   localparam int ST_BUSY = 5;
   localparam int ST_ERR = 6;

   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0;

   // Command codes written to the command register.
   typedef enum logic [OP_W-1:0] {
      xor_word_op = 4'h0,
      xor_double_op = 4'h1,
      xor_bitfield_op = 4'h2,
      xor_stack_op = 4'h3,
      compare_word_op = 4'h4,
      compare_double_op = 4'h5,
      compare_bitfield_op = 4'h6
   } xcau_op_t;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_GATHER
   } xcau_state_t;

endpackage

// [xcau_bit_gather.sv]
`timescale 1ns/100ps
// Collects one discrete bit per cycle, lowest location into bit 0.
module xcau_bit_gather #(
   parameter int DISC_BITS = xcau_pkg::DISC_BITS,
   parameter int IDX_W = xcau_pkg::DISC_IDX_W,
   parameter int ACC_W = xcau_pkg::ACC_W,
   parameter int CNT_W = xcau_pkg::CNT_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic [IDX_W-1:0] startIdx,
   input wire logic [CNT_W-1:0] count,
   input wire logic [DISC_BITS-1:0] discreteBits,
   output logic done,
   output logic [ACC_W-1:0] value
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [IDX_W:0] idx;
      logic [CNT_W-1:0] remaining;
      logic [CNT_W-1:0] pos;
      logic [ACC_W-1:0] value;
   } xcau_gather_t;

   xcau_gather_t q;
   xcau_gather_t d;

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      if (start)
      begin
         // Unused upper bits are cleared before the run begins.
         d.busy = 1'b1;
         d.idx = {1'b0, startIdx};
         d.remaining = count;
         d.pos = '0;
         d.value = '0;
      end
      else if (q.busy)
      begin
         // Locations past the end of the bit image read as zero.
         // The index has one spare bit, so a run near the top cannot wrap to location 0.
         if (int'(q.idx) < DISC_BITS)
         begin
            d.value[q.pos[$clog2(ACC_W)-1:0]] = discreteBits[q.idx[IDX_W-1:0]];
         end
         d.idx = q.idx + 1'b1;
         d.pos = q.pos + 1'b1;
         d.remaining = q.remaining - 1'b1;
         if (q.remaining == CNT_W'(1))
         begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign done = q.done;
   assign value = q.value;

endmodule

// [xcau_unit.sv]
`timescale 1ns/100ps
// What this block does
// - Word XOR: low 16 accumulator bits XOR one memory word, result in accumulator.
// - Double XOR: full accumulator XOR two consecutive words or a constant.
// - Bit-field XOR: accumulator XOR value gathered from a run of discrete bits.
// - Bit-field ops take a start location and an immediate count of 1 to 32.
// - Stack XOR: accumulator XOR top stack level, result in accumulator.
// - After stack XOR the top entry is dropped and the rest move up.
// - Every XOR sets the zero flag exactly when the result is zero.
// - Every XOR sets the negative flag exactly when the result's top bit is one.
// - A flag keeps its value until a later instruction using it executes.
// - Word compare: low 16 accumulator bits against one memory word.
// - Compare sets less, equal or greater by accumulator versus operand.
// - Double compare: full accumulator against two words or a constant.
// - Bit-field compare: accumulator against a counted run of discrete bits.
// - Compare is correct for BCD, hex, decimal or binary alike.
// - A compare changes only the comparison flags and the error flag, never the accumulator.
module xcau_unit #(
   parameter int STACK_DEPTH = xcau_pkg::STACK_DEPTH,
   parameter int DISC_BITS = xcau_pkg::DISC_BITS
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [xcau_pkg::ADDR_W-1:0] address,
   input wire logic [xcau_pkg::ACC_W-1:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [DISC_BITS-1:0] discreteBits,
   output logic [xcau_pkg::ACC_W-1:0] readData,
   output logic zeroFlag,
   output logic negativeFlag,
   output logic lessFlag,
   output logic equalFlag,
   output logic greaterFlag,
   output logic busy
);

   localparam int AW = xcau_pkg::ACC_W;
   localparam int WW = xcau_pkg::WORD_W;
   localparam int IW = xcau_pkg::DISC_IDX_W;
   localparam int CW = xcau_pkg::CNT_W;
   localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);

   typedef struct packed {
      xcau_pkg::xcau_state_t state;
      xcau_pkg::xcau_op_t pendOp;
      logic [AW-1:0] acc;
      logic [WW-1:0] operLo;
      logic [WW-1:0] operHi;
      logic [IW-1:0] fieldStart;
      logic [CW-1:0] fieldCount;
      logic zeroF;
      logic negF;
      logic lessF;
      logic eqF;
      logic gtF;
      logic errF;
      logic gatherStart;
      logic [STACK_DEPTH-1:0][AW-1:0] stack;
      logic [DEPTH_W-1:0] depth;
      logic [AW-1:0] rdata;
   } xcau_top_t;

   xcau_top_t q;
   xcau_top_t d;

   logic gatherDone;
   logic [AW-1:0] gatherValue;
   logic idle;
   logic launch;
   xcau_pkg::xcau_op_t launchOp;
   logic countOk;
   logic isFieldOp;

   assign idle = (q.state == xcau_pkg::ST_IDLE);
   // Commands and operand writes are ignored while a bit field is being gathered.
   assign launch = writeStrobe && (address == xcau_pkg::REG_CMD) && idle;
   assign launchOp = xcau_pkg::xcau_op_t'(writeData[xcau_pkg::OP_W-1:0]);
   assign countOk = (q.fieldCount != '0) && (int'(q.fieldCount) <= xcau_pkg::FIELD_MAX);
   assign isFieldOp = (launchOp == xcau_pkg::xor_bitfield_op)
      || (launchOp == xcau_pkg::compare_bitfield_op);

   xcau_bit_gather #(
      .DISC_BITS(DISC_BITS),
      .IDX_W(IW),
      .ACC_W(AW),
      .CNT_W(CW)
   ) u_gather (
      .clock(clock),
      .rst(rst),
      .start(q.gatherStart),
      .startIdx(q.fieldStart),
      .count(q.fieldCount),
      .discreteBits(discreteBits),
      .done(gatherDone),
      .value(gatherValue)
   );

   always_comb
   begin
      logic doXor;
      logic doCmp;
      logic [AW-1:0] xorOpnd;
      logic [AW-1:0] cmpA;
      logic [AW-1:0] cmpB;
      logic [AW-1:0] res;
      doXor = 1'b0;
      doCmp = 1'b0;
      xorOpnd = '0;
      cmpA = '0;
      cmpB = '0;
      res = '0;
      d = q;
      d.gatherStart = 1'b0;
      d.rdata = '0;

      if (readStrobe)
      begin
         case (address)
            xcau_pkg::REG_ACC: d.rdata = q.acc;
            xcau_pkg::REG_OPER_LO: d.rdata = {{(AW-WW){1'b0}}, q.operLo};
            xcau_pkg::REG_OPER_HI: d.rdata = {{(AW-WW){1'b0}}, q.operHi};
            xcau_pkg::REG_FIELD:
            begin
               d.rdata[xcau_pkg::FIELD_START_LSB +: IW] = q.fieldStart;
               d.rdata[xcau_pkg::FIELD_COUNT_LSB +: CW] = q.fieldCount;
            end
            xcau_pkg::REG_STATUS:
            begin
               d.rdata[xcau_pkg::ST_ZERO] = q.zeroF;
               d.rdata[xcau_pkg::ST_NEG] = q.negF;
               d.rdata[xcau_pkg::ST_LESS] = q.lessF;
               d.rdata[xcau_pkg::ST_EQUAL] = q.eqF;
               d.rdata[xcau_pkg::ST_GREATER] = q.gtF;
               d.rdata[xcau_pkg::ST_BUSY] = !idle;
               d.rdata[xcau_pkg::ST_ERR] = q.errF;
            end
            xcau_pkg::REG_STACK: d.rdata = q.stack[0];
            xcau_pkg::REG_DEPTH: d.rdata = AW'(q.depth);
            default: d.rdata = '0;
         endcase
      end

      if (writeStrobe && idle)
      begin
         case (address)
            xcau_pkg::REG_ACC: d.acc = writeData;
            xcau_pkg::REG_OPER_LO: d.operLo = writeData[WW-1:0];
            xcau_pkg::REG_OPER_HI: d.operHi = writeData[WW-1:0];
            xcau_pkg::REG_FIELD:
            begin
               d.fieldStart = writeData[xcau_pkg::FIELD_START_LSB +: IW];
               d.fieldCount = writeData[xcau_pkg::FIELD_COUNT_LSB +: CW];
            end
            xcau_pkg::REG_STACK:
            begin
               // A push into a full stack is refused rather than losing the bottom.
               if (int'(q.depth) < STACK_DEPTH)
               begin
                  for (int i = STACK_DEPTH - 1; i > 0; i--)
                  begin
                     d.stack[i] = q.stack[i-1];
                  end
                  d.stack[0] = writeData;
                  d.depth = q.depth + 1'b1;
               end
               else
               begin
                  d.errF = 1'b1;
               end
            end
            xcau_pkg::REG_CMD:
            begin
               d.errF = 1'b0;
               case (launchOp)
                  xcau_pkg::xor_word_op:
                  begin
                     doXor = 1'b1;
                     xorOpnd = {{(AW-WW){1'b0}}, q.operLo};
                  end
                  xcau_pkg::xor_double_op:
                  begin
                     doXor = 1'b1;
                     xorOpnd = {q.operHi, q.operLo};
                  end
                  xcau_pkg::xor_stack_op:
                  begin
                     if (q.depth != '0)
                     begin
                        doXor = 1'b1;
                        xorOpnd = q.stack[0];
                        for (int i = 0; i < STACK_DEPTH - 1; i++)
                        begin
                           d.stack[i] = q.stack[i+1];
                        end
                        d.stack[STACK_DEPTH-1] = '0;
                        d.depth = q.depth - 1'b1;
                     end
                     else
                     begin
                        d.errF = 1'b1;
                     end
                  end
                  xcau_pkg::compare_word_op:
                  begin
                     doCmp = 1'b1;
                     cmpA = {{(AW-WW){1'b0}}, q.acc[WW-1:0]};
                     cmpB = {{(AW-WW){1'b0}}, q.operLo};
                  end
                  xcau_pkg::compare_double_op:
                  begin
                     doCmp = 1'b1;
                     cmpA = q.acc;
                     cmpB = {q.operHi, q.operLo};
                  end
                  xcau_pkg::xor_bitfield_op, xcau_pkg::compare_bitfield_op:
                  begin
                     if (countOk)
                     begin
                        d.state = xcau_pkg::ST_GATHER;
                        d.pendOp = launchOp;
                        d.gatherStart = 1'b1;
                     end
                     else
                     begin
                        d.errF = 1'b1;
                     end
                  end
                  default: d.errF = 1'b1;
               endcase
            end
            default: ;
         endcase
      end

      case (q.state)
         xcau_pkg::ST_IDLE: ;
         xcau_pkg::ST_GATHER:
         begin
            if (gatherDone)
            begin
               d.state = xcau_pkg::ST_IDLE;
               if (q.pendOp == xcau_pkg::xor_bitfield_op)
               begin
                  doXor = 1'b1;
                  xorOpnd = gatherValue;
               end
               else
               begin
                  doCmp = 1'b1;
                  cmpA = q.acc;
                  cmpB = gatherValue;
               end
            end
         end
         default: d.state = xcau_pkg::ST_IDLE;
      endcase

      // Zero, negative and comparison flags change only here, when an instruction using them completes.
      if (doXor)
      begin
         res = q.acc ^ xorOpnd;
         d.acc = res;
         d.zeroF = (res == '0);
         d.negF = res[AW-1];
      end
      // Unsigned magnitude order also orders packed BCD digits correctly.
      if (doCmp)
      begin
         d.lessF = (cmpA < cmpB);
         d.eqF = (cmpA == cmpB);
         d.gtF = (cmpA > cmpB);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
         q.state <= xcau_pkg::ST_IDLE;
         q.pendOp <= xcau_pkg::xor_word_op;
         q.acc <= xcau_pkg::ACC_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign readData = q.rdata;
   assign zeroFlag = q.zeroF;
   assign negativeFlag = q.negF;
   assign lessFlag = q.lessF;
   assign equalFlag = q.eqF;
   assign greaterFlag = q.gtF;
   assign busy = q.state != xcau_pkg::ST_IDLE;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_field_launch;
      launch && isFieldOp && countOk;
   endsequence

   sequence s_gather_ends;
      (q.state == xcau_pkg::ST_GATHER) ##[1:40] (q.state == xcau_pkg::ST_IDLE);
   endsequence

   property p_xor_word;
      launch && (launchOp == xcau_pkg::xor_word_op)
         |=> q.acc == ($past(q.acc) ^ {{(AW-WW){1'b0}}, $past(q.operLo)});
   endproperty
   a_xor_word: assert property (p_xor_word) else $error("word xor result wrong");

   property p_xor_double;
      launch && (launchOp == xcau_pkg::xor_double_op)
         |=> q.acc == ($past(q.acc) ^ {$past(q.operHi), $past(q.operLo)});
   endproperty
   a_xor_double: assert property (p_xor_double) else $error("double xor result wrong");

   property p_stack_pop;
      launch && (launchOp == xcau_pkg::xor_stack_op) && (q.depth != '0)
         |=> (q.depth == $past(q.depth) - 1'b1) && (q.acc == ($past(q.acc) ^ $past(q.stack[0])));
   endproperty
   a_stack_pop: assert property (p_stack_pop) else $error("stack xor or pop wrong");

   property p_xor_flags;
      launch && ((launchOp == xcau_pkg::xor_word_op) || (launchOp == xcau_pkg::xor_double_op))
         |=> (zeroFlag == (q.acc == '0)) && (negativeFlag == q.acc[AW-1]);
   endproperty
   a_xor_flags: assert property (p_xor_flags) else $error("xor zero or negative flag wrong");

   property p_cmp_onehot;
      launch && ((launchOp == xcau_pkg::compare_word_op)
         || (launchOp == xcau_pkg::compare_double_op))
         |=> $onehot({lessFlag, equalFlag, greaterFlag}) && $stable(q.acc);
   endproperty
   a_cmp_onehot: assert property (p_cmp_onehot) else $error("compare flags not one-hot");

   property p_cmp_less;
      launch && (launchOp == xcau_pkg::compare_double_op) && (q.acc < {q.operHi, q.operLo})
         |=> lessFlag && !greaterFlag;
   endproperty
   a_cmp_less: assert property (p_cmp_less) else $error("less flag not set");

   property p_cmp_word_eq;
      launch && (launchOp == xcau_pkg::compare_word_op) && (q.acc[WW-1:0] == q.operLo)
         |=> equalFlag;
   endproperty
   a_cmp_word_eq: assert property (p_cmp_word_eq) else $error("word equal flag not set");

   property p_field_finishes;
      s_field_launch |=> s_gather_ends;
   endproperty
   a_field_finishes: assert property (p_field_finishes) else $error("field op did not end");

   property p_bad_count;
      launch && isFieldOp && !countOk |=> idle && q.errF && $stable(q.acc);
   endproperty
   a_bad_count: assert property (p_bad_count) else $error("bad count accepted");

   property p_flags_hold;
      idle && !launch
         |=> $stable({zeroFlag, negativeFlag, lessFlag, equalFlag, greaterFlag});
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flag changed without op");

endmodule

// [xcau_disc_mem.sv]
`timescale 1ns/100ps
// Discrete bit image behind the unit, loaded one 32-bit word at a time.
// Loads come only between instructions, so a gather always sees a steady image.
module xcau_disc_mem #(
   parameter int DISC_BITS = 1024
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic loadStrobe,
   input wire logic [4:0] loadWord,
   input wire logic [31:0] loadValue,
   output logic [DISC_BITS-1:0] discreteBits
);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         discreteBits <= '0;
      else if (loadStrobe)
         discreteBits[loadWord*32 +: 32] <= loadValue;
   end
endmodule

// [xor_compare_accumulator_unit_tb_top.sv]
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module xor_compare_accumulator_unit_tb_top;
   typedef struct {logic [31:0] val; bit isStat;} xcau_note_t;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] address = 4'h0;
   logic [31:0] writeData = 32'h0;
   logic writeStrobe = 1'b0;
   logic readStrobe = 1'b0;
   logic loadStrobe = 1'b0;
   logic [4:0] loadWord = 5'h0;
   logic [31:0] loadValue = 32'h0;
   logic [1023:0] discreteBits;
   logic [31:0] readData;
   logic zeroFlag, negativeFlag, lessFlag, equalFlag, greaterFlag, busy;
   logic rdPend = 1'b0;
   logic [31:0] seed = 32'd98022;
   logic [31:0] accM = 32'h0;
   logic [31:0] stk[$];
   logic [1023:0] img = '0;
   logic zM = 1'b0, nM = 1'b0, lM = 1'b0, eM = 1'b0, gM = 1'b0, errM = 1'b0;
   xcau_note_t notes[$];
   int err_total = 0;
   int num_checks = 0;

   xcau_unit #(.STACK_DEPTH(xcau_pkg::STACK_DEPTH), .DISC_BITS(1024)) DUT (
      .clock(clock), .rst(rst), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .discreteBits(discreteBits),
      .readData(readData), .zeroFlag(zeroFlag), .negativeFlag(negativeFlag),
      .lessFlag(lessFlag), .equalFlag(equalFlag), .greaterFlag(greaterFlag), .busy(busy));
   xcau_disc_mem #(.DISC_BITS(1024)) memModel (
      .clock(clock), .rst(rst), .loadStrobe(loadStrobe), .loadWord(loadWord),
      .loadValue(loadValue), .discreteBits(discreteBits));

   initial
   begin
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic void xr(input logic [31:0] r);
      accM = r;
      zM = (r == 32'h0);
      nM = r[31];
   endfunction

   function automatic void cm(input logic [31:0] a, input logic [31:0] b);
      lM = a < b;
      eM = a == b;
      gM = a > b;
   endfunction

   task automatic give_verdict();
      $display("checks %0d, errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask

   // The note is queued before the strobe so the monitor always finds it.
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input bit s);
      xcau_note_t n;
      n.val = e;
      n.isStat = s;
      notes.push_back(n);
      @(posedge clock);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
   endtask

   task automatic chk_state();
      rd(xcau_pkg::REG_ACC, accM, 1'b0);
      rd(xcau_pkg::REG_STATUS, {25'h0, errM, 1'b0, gM, eM, lM, nM, zM}, 1'b1);
   endtask

   task automatic set_acc(input logic [31:0] d);
      wr(xcau_pkg::REG_ACC, d);
      accM = d;
   endtask

   task automatic push(input logic [31:0] d);
      wr(xcau_pkg::REG_STACK, d);
      if (stk.size() < xcau_pkg::STACK_DEPTH)
         stk.push_back(d);
      else
         errM = 1'b1;
   endtask

   task automatic run(input logic [3:0] op, input logic [31:0] od, input logic [9:0] st,
                      input logic [5:0] cnt);
      logic [31:0] v;
      bit fv;
      int i;
      wr(xcau_pkg::REG_OPER_LO, {16'h0, od[15:0]});
      wr(xcau_pkg::REG_OPER_HI, {16'h0, od[31:16]});
      wr(xcau_pkg::REG_FIELD, {10'h0, cnt, 6'h0, st});
      v = 32'h0;
      for (i = 0; i < 32; i++)
         if (i < cnt && st + i < 1024)
            v[i] = img[st + i];
      fv = (cnt >= 1 && cnt <= 32);
      errM = 1'b0;
      case (op)
         4'h0: xr(accM ^ {16'h0, od[15:0]});
         4'h1: xr(accM ^ od);
         4'h2: if (fv) xr(accM ^ v); else errM = 1'b1;
         4'h3: if (stk.size() > 0) xr(accM ^ stk.pop_back()); else errM = 1'b1;
         4'h4: cm({16'h0, accM[15:0]}, {16'h0, od[15:0]});
         4'h5: cm(accM, od);
         4'h6: if (fv) cm(accM, v); else errM = 1'b1;
         default: errM = 1'b1;
      endcase
      wr(xcau_pkg::REG_CMD, {28'h0, op});
      if ((op == 4'h2 || op == 4'h6) && fv)
      begin
         // Busy rises with the command edge and stays up for count plus two cycles.
         @(negedge clock);
         `CHK(busy, 1'b1)
         for (i = 0; i < 100 && busy !== 1'b0; i++)
            @(negedge clock);
         if (i >= 100)
         begin
            err_total++;
            $display("mismatch at %0t: gather did not finish", $time);
            give_verdict();
         end
         `CHK(i, cnt + 2)
      end
   endtask

   always @(posedge clock)
      rdPend <= readStrobe;

   always @(negedge clock)
   begin
      xcau_note_t n;
      if (rdPend && notes.size() > 0)
      begin
         n = notes.pop_front();
         `CHK(readData, n.val)
         if (n.isStat)
            `CHK({greaterFlag, equalFlag, lessFlag, negativeFlag, zeroFlag}, n.val[4:0])
      end
   end

   initial
   begin
      int w;
      logic [31:0] lv;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      chk_state();
      for (w = 0; w < 32; w++)
      begin
         lv = rnd();
         img[w*32 +: 32] = lv;
         @(posedge clock);
         loadWord <= w[4:0];
         loadValue <= lv;
         loadStrobe <= 1'b1;
      end
      @(posedge clock);
      loadStrobe <= 1'b0;
      set_acc(32'h8000_1234);
      run(4'h0, 32'h5555_ffff, 10'h0, 6'd1);
      chk_state();
      run(4'h1, accM, 10'h0, 6'd1);
      chk_state();
      run(4'h5, 32'h0, 10'h0, 6'd1);
      chk_state();
      set_acc(32'h0001_1999);
      run(4'h4, 32'hffff_2000, 10'h0, 6'd1);
      chk_state();
      run(4'h5, 32'h0001_1998, 10'h0, 6'd1);
      chk_state();
      // Start near the top of the image so the run passes the last location.
      run(4'h2, 32'h0, 10'h3fc, 6'd8);
      chk_state();
      run(4'h6, 32'h0, 10'h005, 6'd32);
      chk_state();
      run(4'h2, 32'h0, 10'h005, 6'd0);
      chk_state();
      run(4'h6, 32'h0, 10'h005, 6'd33);
      chk_state();
      repeat (3) push(rnd());
      run(4'h3, 32'h0, 10'h0, 6'd1);
      chk_state();
      rd(xcau_pkg::REG_STACK, stk[$], 1'b0);
      rd(xcau_pkg::REG_DEPTH, 32'd2, 1'b0);
      repeat (7) push(rnd());
      rd(xcau_pkg::REG_DEPTH, xcau_pkg::STACK_DEPTH, 1'b0);
      repeat (9)
      begin
         run(4'h3, 32'h0, 10'h0, 6'd1);
         chk_state();
      end
      for (w = 4; w < 16; w++)
         if (w != 5 && w != 6 && w != 7)
            rd(w[3:0], 32'h0, 1'b0);
      for (w = 0; w < 60; w++)
      begin
         lv = rnd();
         if (lv[3:0] == 4'h0)
            set_acc(rnd());
         if (lv[7:4] == 4'h1)
            push(rnd());
         run({1'b0, lv[10:8]}, rnd(), lv[21:12], lv[31] ? 6'd32 : {1'b0, lv[30:26]});
         chk_state();
      end
      repeat (3) @(posedge clock);
      give_verdict();
   end
endmodule
